// ### include/eli_pkg.sv
// Constants shared by the error lamp indicator and its flash generator
package eli_pkg;

  // Clock
  localparam int          CLK_HZ            = 25_000_000;
  localparam int          CLK_PERIOD_NS     = 40;

  // Flash rates in flashes per second, and derived half periods in cycles
  localparam int          SYS_FLASH_PER_S   = 2;
  localparam int          PROTO_FLASH_PER_S = 1;
  localparam int          SYS_HALF_CYC      = CLK_HZ / (2 * SYS_FLASH_PER_S);
  localparam int          PROTO_HALF_CYC    = CLK_HZ / (2 * PROTO_FLASH_PER_S);

  // One second in cycles, used as the hold time base
  localparam int          SEC_S             = 1;
  localparam int          SEC_CYC           = CLK_HZ * SEC_S;

  // System warning hold time in seconds (one minute)
  localparam logic [15:0] WARN_HOLD_S       = 16'h003c;
  localparam logic [15:0] HOLD_RST          = 16'h0000;

  // Error numbers
  localparam logic [3:0]  CODE_NONE         = 4'h0;
  localparam logic [3:0]  SERIOUS_MAX       = 4'h5;
  localparam logic [3:0]  CODE_FRAME        = 4'hb;
  localparam logic [3:0]  CODE_FB_OVF       = 4'he;
  localparam logic [3:0]  CODE_TIMEOUT      = 4'h9;
  localparam logic [3:0]  CODE_CHECKSUM     = 4'hb;
  localparam logic [3:0]  CODE_ENCODER      = 4'hc;

endpackage : eli_pkg

// ### hw/eli_lamp_flash.sv
// Flash phase generator with a fast (system) and a slow (protocol) rate
`timescale 1ns/10ps
`default_nettype none
module eli_lamp_flash #(
  parameter int HALF_SYS   = eli_pkg::SYS_HALF_CYC,
  parameter int HALF_PROTO = eli_pkg::PROTO_HALF_CYC
) (
  // Clock and reset
  input  wire logic clk,
  input  wire logic resetn,
  // Control
  input  wire logic active,
  input  wire logic slowRate,
  input  wire logic restart,
  // Phase
  output logic      lit
);
  import eli_pkg::*;

  localparam int CW = $clog2((HALF_PROTO > HALF_SYS ? HALF_PROTO : HALF_SYS) + 1);

  typedef struct packed {
    logic [CW-1:0] cnt;
    logic          lit;
  } eli_flash_s;

  eli_flash_s    q, d;
  logic [CW-1:0] limit;

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    d     = q;
    limit = slowRate ? CW'(HALF_PROTO - 1) : CW'(HALF_SYS - 1);
    if (restart || !active) begin
      // Restart shows the code at once instead of waiting a half period
      d.cnt = '0;
      d.lit = 1'b1;
    end else if (q.cnt >= limit) begin
      d.cnt = '0;
      d.lit = ~q.lit;
    end else begin
      d.cnt = q.cnt + 1'b1;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign lit = q.lit;

  ////////////////////////////////////////////////////////////////////////////
  property p_sys_toggle;
    @(posedge clk) disable iff (!resetn)
      active && !restart && !slowRate && q.cnt == CW'(HALF_SYS - 1) |=> lit != $past(lit);
  endproperty
  a_sys_toggle: assert property (p_sys_toggle) else $error("system flash did not toggle");

  property p_proto_toggle;
    @(posedge clk) disable iff (!resetn)
      active && !restart && slowRate && q.cnt == CW'(HALF_PROTO - 1) |=> lit != $past(lit);
  endproperty
  a_proto_toggle: assert property (p_proto_toggle) else $error("slow flash did not toggle");

  property p_hold_phase;
    @(posedge clk) disable iff (!resetn)
      active && !restart && q.cnt < limit |=> $stable(lit);
  endproperty
  a_hold_phase: assert property (p_hold_phase) else $error("flash phase changed early");

endmodule : eli_lamp_flash
`default_nettype wire

// ### hw/eli_error_lamp_indicator.sv
// Error lamp indicator: latches error numbers and drives state and number lamps
//
// Function
// - Outside configuration mode, any accepted error lights the state lamp red and shows its number on the four lamps.
// - Errors one to five stay latched until power-up reset.
// - Errors six to fifteen from the system side are shown one minute, then clear themselves.
// - In configuration mode the number lamps are blanked and flagged not valid.
// - The four lamps carry the number in binary 8-4-2-1; a framing failure shows eleven.
// - A fieldbus data buffer overflow shows system error fourteen.
// - System errors flash the lamps two times per second.
// - Protocol and user errors flash once per second to tell them from system errors.
// - Protocol errors and user errors six to fifteen stay shown for the configured warning hold time.
// - A missing answer from a polled participant raises protocol error nine.
// - A checksum mismatch raises protocol error eleven.
// - A serial encoder link failure raises protocol error twelve.
`timescale 1ns/10ps
`default_nettype none
module eli_error_lamp_indicator #(
  parameter int SEC_CYC_P    = eli_pkg::SEC_CYC,
  parameter int HALF_SYS_P   = eli_pkg::SYS_HALF_CYC,
  parameter int HALF_PROTO_P = eli_pkg::PROTO_HALF_CYC
) (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        resetn,
  // System error sources
  input  wire logic        sysErrValid,
  input  wire logic [3:0]  sysErrCode,
  input  wire logic        frameCheckFail,
  input  wire logic        fieldbusBufOverflow,
  // Protocol error sources
  input  wire logic        respTimeout,
  input  wire logic        checksumMismatch,
  input  wire logic        encoderLinkFail,
  input  wire logic        userErrValid,
  input  wire logic [3:0]  userErrCode,
  // Configuration
  input  wire logic        configMode,
  input  wire logic [15:0] warnHoldSec,
  // Lamps
  output logic             stateLampRed,
  output logic             lamp_weight_eight,
  output logic             lamp_weight_four,
  output logic             lamp_weight_two,
  output logic             lamp_weight_one,
  output logic             errorCodeValid
);
  import eli_pkg::*;

  localparam int SEC_W = $clog2(SEC_CYC_P + 1);

  typedef struct packed {
    logic             active;
    logic             serious;
    logic             proto;
    logic [3:0]       code;
    logic [15:0]      holdSec;
    logic [SEC_W-1:0] secCnt;
    logic             red;
    logic [3:0]       lamps;
    logic             valid;
  } eli_state_s;

  eli_state_s q, d;
  logic       evt;
  logic       evtProto;
  logic [3:0] evtCode;
  logic       secTick;
  logic       accept;
  logic       flashLit;

  ////////////////////////////////////////////////////////////////////////////
  // Event selection; the lowest branch wins only when nothing above fires.
  // Simultaneous events beyond the winner are dropped, a trade for one latch.
  always_comb begin
    evt      = 1'b1;
    evtProto = 1'b0;
    evtCode  = CODE_NONE;
    if (sysErrValid && sysErrCode != CODE_NONE) begin
      evtCode = sysErrCode;
    end else if (frameCheckFail) begin
      evtCode = CODE_FRAME;
    end else if (fieldbusBufOverflow) begin
      evtCode = CODE_FB_OVF;
    end else if (respTimeout) begin
      evtCode  = CODE_TIMEOUT;
      evtProto = 1'b1;
    end else if (checksumMismatch) begin
      evtCode  = CODE_CHECKSUM;
      evtProto = 1'b1;
    end else if (encoderLinkFail) begin
      evtCode  = CODE_ENCODER;
      evtProto = 1'b1;
    end else if (userErrValid && userErrCode != CODE_NONE) begin
      evtCode  = userErrCode;
      evtProto = 1'b1;
    end else begin
      evt = 1'b0;
    end
  end

  assign secTick = (q.secCnt == SEC_W'(SEC_CYC_P - 1));
  assign accept  = evt && !q.serious;

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    d        = q;
    d.secCnt = secTick ? '0 : q.secCnt + 1'b1;
    if (q.active && !q.serious && secTick) begin
      if (q.holdSec <= 16'h0001) begin
        d.active = 1'b0;
      end else begin
        d.holdSec = q.holdSec - 16'h0001;
      end
    end
    if (accept) begin
      d.active  = 1'b1;
      d.code    = evtCode;
      d.proto   = evtProto;
      d.serious = (evtCode <= SERIOUS_MAX);
      d.holdSec = evtProto ? warnHoldSec : WARN_HOLD_S;
      d.secCnt  = '0;
    end
    // Lamp pattern means nothing in configuration mode, so it is blanked
    d.valid = d.active && !configMode;
    d.red   = d.valid;
    // A new error shows its number with the red lamp, whatever the old flash phase
    d.lamps = (d.valid && (flashLit || accept)) ? d.code : 4'h0;
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  eli_lamp_flash #(
    .HALF_SYS   (HALF_SYS_P),
    .HALF_PROTO (HALF_PROTO_P)
  ) u_flash (
    .clk      (clk),
    .resetn   (resetn),
    .active   (q.active),
    .slowRate (q.proto),
    .restart  (accept),
    .lit      (flashLit)
  );

  assign stateLampRed      = q.red;
  assign lamp_weight_eight = q.lamps[3];
  assign lamp_weight_four  = q.lamps[2];
  assign lamp_weight_two   = q.lamps[1];
  assign lamp_weight_one   = q.lamps[0];
  assign errorCodeValid    = q.valid;

  ////////////////////////////////////////////////////////////////////////////
  sequence s_err_taken;
    accept && !configMode;
  endsequence

  sequence s_err_shown;
    stateLampRed && errorCodeValid
    && {lamp_weight_eight, lamp_weight_four, lamp_weight_two, lamp_weight_one} == q.code;
  endsequence

  property p_red_on_error;
    @(posedge clk) disable iff (!resetn)
      s_err_taken ##1 !configMode |-> s_err_shown;
  endproperty
  a_red_on_error: assert property (p_red_on_error) else $error("no red lamp on error");

  property p_serious_sticks;
    @(posedge clk) disable iff (!resetn)
      q.serious |=> q.serious && q.active && $stable(q.code);
  endproperty
  a_serious_sticks: assert property (p_serious_sticks) else $error("serious error lost");

  property p_warn_count;
    @(posedge clk) disable iff (!resetn)
      q.active && !q.serious && secTick && q.holdSec > 16'h0001 && !evt
      |=> q.holdSec == $past(q.holdSec) - 16'h0001;
  endproperty
  a_warn_count: assert property (p_warn_count) else $error("hold time not counted");

  property p_warn_end;
    @(posedge clk) disable iff (!resetn)
      q.active && !q.serious && secTick && q.holdSec <= 16'h0001 && !evt |=> !q.active;
  endproperty
  a_warn_end: assert property (p_warn_end) else $error("warning did not clear");

  property p_config_blank;
    @(posedge clk) disable iff (!resetn)
      configMode |=> !errorCodeValid && q.lamps == 4'h0 && !stateLampRed;
  endproperty
  a_config_blank: assert property (p_config_blank) else $error("lamps shown in config");

  property p_lamp_binary;
    @(posedge clk) disable iff (!resetn)
      q.lamps != 4'h0 |-> q.lamps == q.code && errorCodeValid;
  endproperty
  a_lamp_binary: assert property (p_lamp_binary) else $error("lamps differ from code");

  property p_frame_code;
    @(posedge clk) disable iff (!resetn)
      frameCheckFail && !q.serious && !(sysErrValid && sysErrCode != CODE_NONE)
      |=> q.code == CODE_FRAME && !q.proto;
  endproperty
  a_frame_code: assert property (p_frame_code) else $error("frame failure not eleven");

  property p_ovf_code;
    @(posedge clk) disable iff (!resetn)
      fieldbusBufOverflow && !q.serious && !frameCheckFail
      && !(sysErrValid && sysErrCode != CODE_NONE) |=> q.code == CODE_FB_OVF;
  endproperty
  a_ovf_code: assert property (p_ovf_code) else $error("overflow not fourteen");

  property p_proto_hold;
    @(posedge clk) disable iff (!resetn)
      accept && evtProto |=> q.holdSec == $past(warnHoldSec) && q.proto;
  endproperty
  a_proto_hold: assert property (p_proto_hold) else $error("hold time not loaded");

  property p_timeout_code;
    @(posedge clk) disable iff (!resetn)
      accept && evtProto && respTimeout |=> q.code == CODE_TIMEOUT;
  endproperty
  a_timeout_code: assert property (p_timeout_code) else $error("timeout not nine");

  property p_checksum_code;
    @(posedge clk) disable iff (!resetn)
      accept && evtProto && checksumMismatch && !respTimeout |=> q.code == CODE_CHECKSUM;
  endproperty
  a_checksum_code: assert property (p_checksum_code) else $error("checksum not eleven");

  property p_encoder_code;
    @(posedge clk) disable iff (!resetn)
      accept && evtProto && encoderLinkFail && !respTimeout && !checksumMismatch
      |=> q.code == CODE_ENCODER;
  endproperty
  a_encoder_code: assert property (p_encoder_code) else $error("encoder not twelve");

  property p_no_override;
    @(posedge clk) disable iff (!resetn)
      q.serious && evt |=> q.code == $past(q.code);
  endproperty
  a_no_override: assert property (p_no_override) else $error("serious code replaced");

endmodule : eli_error_lamp_indicator
`default_nettype wire

// ### sim/eli_lamp_panel.sv
// Front panel lamp model: reads the shown number and the flash half period
`timescale 1ns/10ps
`default_nettype none
module eli_lamp_panel (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        resetn,
  // Lamps
  input  wire logic        lamp_weight_eight,
  input  wire logic        lamp_weight_four,
  input  wire logic        lamp_weight_two,
  input  wire logic        lamp_weight_one,
  // Observation
  output logic      [3:0]  shownCode,
  output logic      [15:0] halfLen
);
  logic [3:0]  pat;
  logic [3:0]  prevPat_q;
  logic [15:0] run_q;
  assign pat = {lamp_weight_eight, lamp_weight_four, lamp_weight_two, lamp_weight_one};
  // A dark phase carries no number, so only a lit pattern is kept
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      prevPat_q <= 4'h0;
      run_q     <= 16'h0000;
      halfLen   <= 16'h0000;
      shownCode <= 4'h0;
    end else begin
      prevPat_q <= pat;
      if (pat != 4'h0) begin
        shownCode <= pat;
      end
      if (pat != prevPat_q) begin
        halfLen <= run_q;
        run_q   <= 16'h0001;
      end else begin
        run_q <= run_q + 16'h0001;
      end
    end
  end
endmodule : eli_lamp_panel
`default_nettype wire

// ### sim/tb.sv
// Self-checking bench for the error lamp indicator
`timescale 1ns/10ps
`default_nettype none
module tb;
  import eli_pkg::*;
  logic        clk;
  logic        resetn;
  logic [6:0]  ev;
  logic [3:0]  sysCode;
  logic [3:0]  userCode;
  logic        configMode;
  logic [15:0] warnHoldSec;
  logic        red;
  logic        valid;
  logic [3:0]  lamps;
  logic [3:0]  shownCode;
  logic [15:0] halfLen;
  int          fail_count;
  int          check_count;
  int          cycles = 0;

  eli_error_lamp_indicator #(.SEC_CYC_P(20), .HALF_SYS_P(3), .HALF_PROTO_P(6)) dut (
    .clk(clk), .resetn(resetn),
    .sysErrValid(ev[0]), .sysErrCode(sysCode), .frameCheckFail(ev[1]),
    .fieldbusBufOverflow(ev[2]), .respTimeout(ev[3]), .checksumMismatch(ev[4]),
    .encoderLinkFail(ev[5]), .userErrValid(ev[6]), .userErrCode(userCode),
    .configMode(configMode), .warnHoldSec(warnHoldSec), .stateLampRed(red),
    .lamp_weight_eight(lamps[3]), .lamp_weight_four(lamps[2]),
    .lamp_weight_two(lamps[1]), .lamp_weight_one(lamps[0]), .errorCodeValid(valid));

  eli_lamp_panel panel (
    .clk(clk), .resetn(resetn), .lamp_weight_eight(lamps[3]), .lamp_weight_four(lamps[2]),
    .lamp_weight_two(lamps[1]), .lamp_weight_one(lamps[0]),
    .shownCode(shownCode), .halfLen(halfLen));

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk

  task automatic fire(input int i, input logic [3:0] c);
    @(negedge clk);
    ev[i]    = 1'b1;
    sysCode  = c;
    userCode = c;
    @(negedge clk);
    ev = 7'h00;
  endtask : fire

  task automatic do_reset();
    @(negedge clk);
    resetn = 1'b0;
    repeat (4) @(negedge clk);
    resetn = 1'b1;
  endtask : do_reset

  task automatic t_frame();
    fire(1, 4'h0);
    repeat (12) @(negedge clk);
    chk("red", {15'h0, red}, 16'h0001);
    chk("valid", {15'h0, valid}, 16'h0001);
    chk("code", {12'h0, shownCode}, {12'h0, CODE_FRAME});
    chk("half", halfLen, 16'h0003);
    repeat (1187) @(negedge clk);
    chk("red held", {15'h0, red}, 16'h0001);
    repeat (1) @(negedge clk);
    chk("red clear", {15'h0, red}, 16'h0000);
    chk("lamps clear", {12'h0, lamps}, 16'h0000);
  endtask : t_frame

  task automatic t_replace();
    fire(2, 4'h0);
    repeat (12) @(negedge clk);
    chk("code", {12'h0, shownCode}, {12'h0, CODE_FB_OVF});
    fire(3, 4'h0);
    repeat (24) @(negedge clk);
    chk("code", {12'h0, shownCode}, {12'h0, CODE_TIMEOUT});
    chk("half", halfLen, 16'h0006);
    chk("red held", {15'h0, red}, 16'h0001);
    repeat (15) @(negedge clk);
    chk("red held", {15'h0, red}, 16'h0001);
    repeat (1) @(negedge clk);
    chk("red clear", {15'h0, red}, 16'h0000);
  endtask : t_replace

  task automatic t_proto();
    fire(4, 4'h0);
    repeat (20) @(negedge clk);
    chk("code", {12'h0, shownCode}, {12'h0, CODE_CHECKSUM});
    fire(5, 4'h0);
    repeat (20) @(negedge clk);
    chk("code", {12'h0, shownCode}, {12'h0, CODE_ENCODER});
    fire(6, 4'h7);
    repeat (20) @(negedge clk);
    chk("code", {12'h0, shownCode}, 16'h0007);
    chk("half", halfLen, 16'h0006);
    configMode = 1'b1;
    repeat (8) @(negedge clk);
    chk("valid", {15'h0, valid}, 16'h0000);
    chk("lamps", {12'h0, lamps}, 16'h0000);
    configMode = 1'b0;
    repeat (3) @(negedge clk);
    chk("valid", {15'h0, valid}, 16'h0001);
  endtask : t_proto

  task automatic t_serious();
    fire(0, 4'h3);
    repeat (12) @(negedge clk);
    chk("code", {12'h0, shownCode}, 16'h0003);
    fire(1, 4'h0);
    repeat (12) @(negedge clk);
    chk("code", {12'h0, shownCode}, 16'h0003);
    chk("half", halfLen, 16'h0003);
    repeat (1300) @(negedge clk);
    chk("red held", {15'h0, red}, 16'h0001);
    do_reset();
    chk("red off", {15'h0, red}, 16'h0000);
  endtask : t_serious

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : give_verdict

  // The limit sits far above the roughly 2700 cycles that the scenarios need
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      fail_count++;
      give_verdict();
    end
  end

  initial begin
    resetn      = 1'b0;
    ev          = 7'h00;
    sysCode     = 4'h0;
    userCode    = 4'h0;
    configMode  = 1'b0;
    warnHoldSec = 16'h0002;
    fail_count  = 0;
    check_count = 0;
    do_reset();
    t_frame();
    do_reset();
    t_replace();
    do_reset();
    t_proto();
    do_reset();
    t_serious();
    give_verdict();
  end
endmodule : tb
`default_nettype wire
